/* File: hw/sosr_pkg.sv */
/*
 * Constants and carrier types of the sensor output, status and reset register bank.
 * Assumes one 200 MHz core clock and a byte-wide register access port in front of the bank.
 */
package sosr_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_EVENT_CFG = 8'h0B;
  localparam logic [7:0] ADDR_THS_LOW = 8'h0C;
  localparam logic [7:0] ADDR_THS_HIGH = 8'h0D;
  localparam logic [7:0] ADDR_IF_CFG = 8'h0E;
  localparam logic [7:0] ADDR_RATE_SELECT = 8'h10;
  localparam logic [7:0] ADDR_UPDATE_RELOAD = 8'h11;
  localparam logic [7:0] ADDR_ADDR_CTRL = 8'h12;
  localparam logic [7:0] ADDR_IRQ_ROUTING = 8'h13;
  localparam logic [7:0] ADDR_QUEUE_CTRL = 8'h14;
  localparam logic [7:0] ADDR_QUEUE_MARK = 8'h15;
  localparam logic [7:0] ADDR_TRIM_LOW = 8'h1A;
  localparam logic [7:0] ADDR_TRIM_HIGH = 8'h1B;
  localparam logic [7:0] ADDR_EVENT_SOURCE = 8'h24;
  localparam logic [7:0] ADDR_QUEUE_FIRST = 8'h25;
  localparam logic [7:0] ADDR_QUEUE_SECOND = 8'h26;
  localparam logic [7:0] ADDR_SAMPLE_FLAGS = 8'h27;
  localparam logic [7:0] ADDR_PRESS_LOW = 8'h28;
  localparam logic [7:0] ADDR_PRESS_MID = 8'h29;
  localparam logic [7:0] ADDR_PRESS_HIGH = 8'h2A;
  localparam logic [7:0] ADDR_TEMP_LOW = 8'h2B;
  localparam logic [7:0] ADDR_TEMP_HIGH = 8'h2C;
  localparam logic [7:0] ADDR_QOUT_FIRST = 8'h78;
  localparam logic [7:0] ADDR_QOUT_LAST = 8'h7A;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RELOAD_BIT = 7;
  localparam int UPD_BIT = 3;
  localparam int SOFT_RESET_BIT = 2;
  localparam int ONE_SHOT_BIT = 0;
  localparam int AUTO_INC_BIT = 2;
  localparam int ZERO_REF_BIT = 5;
  localparam int RDY_ROUTE_BIT = 5;
  localparam int BOOT_FLAG_BIT = 7;
  localparam int P_AV_BIT = 0;
  localparam int T_AV_BIT = 1;
  localparam int P_OR_BIT = 4;
  localparam int T_OR_BIT = 5;
  localparam int RATE_MSB = 6;
  localparam int RATE_LSB = 3;

  // ****************************************************************
  // Reset values and queue routing mask
  // ****************************************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ADDR_CTRL = 8'h04;
  localparam logic [2:0] QUEUE_ROUTE_MASK = 3'h7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 200;
  localparam int BOOT_TIME_MS = 10;
  localparam int SOFT_RESET_TIME_US = 40;
  localparam int BOOT_CYCLES = BOOT_TIME_MS * 1000 * CLK_MHZ;
  localparam int SOFT_RESET_CYCLES = SOFT_RESET_TIME_US * CLK_MHZ;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [23:0] pressure;
    logic [15:0] temperature;
  } sosr_sample_t;

  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
  } sosr_queue_state_t;

  typedef enum logic [2:0] {
    SOSR_BOOT = 3'h1,
    SOSR_IDLE = 3'h2,
    SOSR_SRST = 3'h4
  } sosr_state_t;

endpackage : sosr_pkg

/* File: hw/sosr_bank.sv */
/*
 * Output, status and reset register bank of a pressure and temperature sensor.
 * Assumes a serial front end that gives a byte port (start with address, then
 * read or write strobes) and a conversion engine on the same clock.
 */
// Functional notes
// - A new sample sets the pressure and temperature available flags.
// - Reading the high pressure byte clears the pressure available flag.
// - Reading the high temperature byte clears the temperature available flag.
// - A sample arriving while its available flag is set sets its overrun flag.
// - Overrun flags clear once all data is read and nothing new arrived.
// - Both available flags rise together and clear independently.
// - One-shot takes one sample then self-clears its request bit.
// - The data-ready routing bit drives pressure available onto the interrupt pin.
// - Interrupt pin is OR of routed data-ready and routed queue interrupts.
// - Block update holds a started sample until its high byte is read.
// - Pressure and temperature lock separately, released by their high byte read.
// - Block update also locks queue state; first must be read before second.
// - Pressure is 24-bit two's complement, low byte at the lowest address.
// - Temperature is 16-bit two's complement, low byte first.
// - Power-up boot lasts at most the boot time, then power-down.
// - Register accesses are not serviced while boot runs.
// - Reload clears offset trim, forces power-down and self-clears its bit.
// - Soft reset returns the control, queue, event and flag registers to defaults.
// - Soft reset bit reads one until the reset completes.
// - Auto-increment advances the address after each byte when enabled.
// - Auto-increment wraps at the end of the sample ranges.
`timescale 1ns/1ps
`default_nettype none

module sosr_bank #(
  parameter int BOOT_CYCLES = sosr_pkg::BOOT_CYCLES,
  parameter int SOFT_RESET_CYCLES = sosr_pkg::SOFT_RESET_CYCLES
) (
  input wire logic core_clk_in, // Core clock, 200 MHz.
  input wire logic rst_b_in, // Synchronous reset, active low.
  input wire logic reg_start_in, // Pulse: load address pointer.
  input wire logic [7:0] reg_addr_in, // Start address.
  input wire logic reg_rd_in, // Pulse: read byte at pointer.
  input wire logic reg_wr_in, // Pulse: write byte at pointer.
  input wire logic [7:0] reg_wdata_in, // Write data.
  output logic reg_ready_out, // High when accesses are serviced.
  output logic reg_rvalid_out, // Pulse: read data valid.
  output logic [7:0] reg_rdata_out, // Read data.
  input wire logic sample_valid_in, // Pulse: new sample from conversion.
  input wire sosr_pkg::sosr_sample_t sample_in, // Sample values.
  input wire sosr_pkg::sosr_queue_state_t queue_state_in, // Live queue state.
  input wire logic [2:0] queue_irq_in, // Queue interrupt signals.
  output logic [3:0] output_rate_select_out, // Selected rate, zero is power-down.
  output logic [2:0] averaging_select_out, // Averaging selection.
  output logic one_shot_req_out, // Pulse: start one measurement.
  output logic zero_reference_mode_out, // Differential output mode.
  output logic trim_load_out, // High while trim parameters load.
  output logic interrupt_output_pin // Interrupt pin level.
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  sosr_pkg::sosr_state_t state_reg;
  logic [31:0] timer_reg;
  logic [7:0] ptr_reg;
  logic [7:0] gen_reg [0:7];
  logic [7:0] rate_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] route_reg;
  logic [7:0] trim_low_reg;
  logic [7:0] trim_high_reg;
  logic p_av_reg, t_av_reg, p_or_reg, t_or_reg;
  logic p_lock_reg, t_lock_reg, q_lock_reg;
  logic [23:0] p_latest_reg, p_held_reg;
  logic [15:0] t_latest_reg, t_held_reg;
  logic [7:0] q_second_held_reg;
  logic oneshot_busy_reg;
  logic rd_ok, wr_ok, upd;
  logic [3:0] slot;
  logic [23:0] p_view;
  logic [15:0] t_view;
  logic rd_p_hi, rd_t_hi;
  logic srst_done;

  // Maps a general storage address to its slot, eight meaning none.
  function automatic logic [3:0] gen_slot(input logic [7:0] a);
    case (a)
      sosr_pkg::ADDR_EVENT_CFG: gen_slot = 4'h0;
      sosr_pkg::ADDR_THS_LOW: gen_slot = 4'h1;
      sosr_pkg::ADDR_THS_HIGH: gen_slot = 4'h2;
      sosr_pkg::ADDR_IF_CFG: gen_slot = 4'h3;
      sosr_pkg::ADDR_ADDR_CTRL: gen_slot = 4'h4;
      sosr_pkg::ADDR_QUEUE_CTRL: gen_slot = 4'h5;
      sosr_pkg::ADDR_QUEUE_MARK: gen_slot = 4'h6;
      default: gen_slot = 4'h8;
    endcase
  endfunction : gen_slot

  // Next pointer after a byte, wrapping inside the sample ranges.
  function automatic logic [7:0] next_ptr(input logic [7:0] a);
    if (a == sosr_pkg::ADDR_TEMP_HIGH) begin
      next_ptr = sosr_pkg::ADDR_PRESS_LOW;
    end else if (a == sosr_pkg::ADDR_QOUT_LAST) begin
      next_ptr = sosr_pkg::ADDR_QOUT_FIRST;
    end else begin
      next_ptr = a + 8'h01;
    end
  endfunction : next_ptr

  // ****************************************************************
  // Access qualification
  // ****************************************************************
  // Accesses are refused during boot; reads see the locked or live view.
  assign reg_ready_out = (state_reg != sosr_pkg::SOSR_BOOT);
  assign rd_ok = reg_rd_in && reg_ready_out;
  assign wr_ok = reg_wr_in && reg_ready_out;
  assign upd = ctrl_reg[sosr_pkg::UPD_BIT];
  assign slot = gen_slot(ptr_reg);
  assign p_view = p_lock_reg ? p_held_reg : p_latest_reg;
  assign t_view = t_lock_reg ? t_held_reg : t_latest_reg;
  assign rd_p_hi = rd_ok && (ptr_reg == sosr_pkg::ADDR_PRESS_HIGH);
  assign rd_t_hi = rd_ok && (ptr_reg == sosr_pkg::ADDR_TEMP_HIGH);
  assign srst_done = (state_reg == sosr_pkg::SOSR_SRST) && (timer_reg == 32'h0000_0000);

  // ****************************************************************
  // Boot, reload and soft reset sequencing
  // ****************************************************************
  // Boot runs from reset and on a reload request; soft reset has its own wait.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      state_reg <= sosr_pkg::SOSR_BOOT;
      timer_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        sosr_pkg::SOSR_BOOT: begin
          if (timer_reg >= 32'(BOOT_CYCLES - 1)) begin
            state_reg <= sosr_pkg::SOSR_IDLE;
            timer_reg <= 32'h0000_0000;
          end else begin
            timer_reg <= timer_reg + 32'h0000_0001;
          end
        end
        sosr_pkg::SOSR_IDLE: begin
          if (wr_ok && ptr_reg == sosr_pkg::ADDR_UPDATE_RELOAD) begin
            if (reg_wdata_in[sosr_pkg::RELOAD_BIT]) begin
              state_reg <= sosr_pkg::SOSR_BOOT;
              timer_reg <= 32'h0000_0000;
            end else if (reg_wdata_in[sosr_pkg::SOFT_RESET_BIT]) begin
              state_reg <= sosr_pkg::SOSR_SRST;
              timer_reg <= 32'(SOFT_RESET_CYCLES - 1);
            end
          end
        end
        sosr_pkg::SOSR_SRST: begin
          if (timer_reg == 32'h0000_0000) begin
            state_reg <= sosr_pkg::SOSR_IDLE;
          end else begin
            timer_reg <= timer_reg - 32'h0000_0001;
          end
        end
        default: begin
          state_reg <= sosr_pkg::SOSR_IDLE;
          timer_reg <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************************************
  // Address pointer
  // ****************************************************************
  // The pointer loads on start and advances after each byte when enabled.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      ptr_reg <= 8'h00;
    end else if (reg_start_in) begin
      ptr_reg <= reg_addr_in;
    end else if ((rd_ok || wr_ok) && gen_reg[4][sosr_pkg::AUTO_INC_BIT]) begin
      ptr_reg <= next_ptr(ptr_reg);
    end
  end

  // ****************************************************************
  // General control storage
  // ****************************************************************
  // Plain read-write registers; the soft reset puts them back to defaults.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in || srst_done) begin
      for (int i = 0; i < 8; i++) begin
        gen_reg[i] <= sosr_pkg::RST_ZERO;
      end
      gen_reg[4] <= sosr_pkg::RST_ADDR_CTRL;
    end else if (wr_ok && slot != 4'h8) begin
      gen_reg[slot[2:0]] <= reg_wdata_in;
    end
  end

  // Rate select and routing; reload forces power-down.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in || srst_done) begin
      rate_reg <= sosr_pkg::RST_ZERO;
      route_reg <= sosr_pkg::RST_ZERO;
    end else if (state_reg == sosr_pkg::SOSR_BOOT) begin
      rate_reg[sosr_pkg::RATE_MSB:sosr_pkg::RATE_LSB] <= 4'h0;
    end else if (wr_ok && ptr_reg == sosr_pkg::ADDR_RATE_SELECT) begin
      rate_reg <= reg_wdata_in;
    end else if (wr_ok && ptr_reg == sosr_pkg::ADDR_IRQ_ROUTING) begin
      route_reg <= reg_wdata_in;
    end
  end

  // Update and reload control; the self-clearing bits drop when their work ends.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in || srst_done) begin
      ctrl_reg <= sosr_pkg::RST_ZERO;
    end else begin
      if (wr_ok && ptr_reg == sosr_pkg::ADDR_UPDATE_RELOAD) begin
        ctrl_reg <= reg_wdata_in;
      end
      if (state_reg == sosr_pkg::SOSR_BOOT && timer_reg >= 32'(BOOT_CYCLES - 1)) begin
        ctrl_reg[sosr_pkg::RELOAD_BIT] <= 1'b0;
      end
      if (oneshot_busy_reg && sample_valid_in) begin
        ctrl_reg[sosr_pkg::ONE_SHOT_BIT] <= 1'b0;
      end
    end
  end

  // One-shot issues one request and waits for its sample.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in || srst_done || state_reg == sosr_pkg::SOSR_BOOT) begin
      oneshot_busy_reg <= 1'b0;
      one_shot_req_out <= 1'b0;
    end else begin
      one_shot_req_out <= 1'b0;
      if (wr_ok && ptr_reg == sosr_pkg::ADDR_UPDATE_RELOAD
          && reg_wdata_in[sosr_pkg::ONE_SHOT_BIT] && !oneshot_busy_reg) begin
        oneshot_busy_reg <= 1'b1;
        one_shot_req_out <= 1'b1;
      end else if (sample_valid_in) begin
        oneshot_busy_reg <= 1'b0;
      end
    end
  end

  // Offset trim is cleared by reset and by a reload, not by soft reset.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in || state_reg == sosr_pkg::SOSR_BOOT) begin
      trim_low_reg <= sosr_pkg::RST_ZERO;
      trim_high_reg <= sosr_pkg::RST_ZERO;
    end else if (wr_ok && ptr_reg == sosr_pkg::ADDR_TRIM_LOW) begin
      trim_low_reg <= reg_wdata_in;
    end else if (wr_ok && ptr_reg == sosr_pkg::ADDR_TRIM_HIGH) begin
      trim_high_reg <= reg_wdata_in;
    end
  end

  // ****************************************************************
  // Sample flags
  // ****************************************************************
  // Both flags rise on one sample; a set in the read cycle wins over the clear.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in || srst_done) begin
      p_av_reg <= 1'b0;
      t_av_reg <= 1'b0;
      p_or_reg <= 1'b0;
      t_or_reg <= 1'b0;
    end else if (sample_valid_in) begin
      p_av_reg <= 1'b1;
      t_av_reg <= 1'b1;
      if (p_av_reg) begin
        p_or_reg <= 1'b1;
      end
      if (t_av_reg) begin
        t_or_reg <= 1'b1;
      end
    end else begin
      if (rd_p_hi) begin
        p_av_reg <= 1'b0;
      end
      if (rd_t_hi) begin
        t_av_reg <= 1'b0;
      end
      if ((rd_p_hi || !p_av_reg) && (rd_t_hi || !t_av_reg) && (rd_p_hi || rd_t_hi)) begin
        p_or_reg <= 1'b0;
        t_or_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Sample data and block update locks
  // ****************************************************************
  // The latest sample always lands; a lock freezes the visible copy.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      p_latest_reg <= 24'h00_0000;
      t_latest_reg <= 16'h0000;
    end else if (sample_valid_in) begin
      p_latest_reg <= sample_in.pressure;
      t_latest_reg <= sample_in.temperature;
    end
  end

  // Pressure lock starts on a low or middle byte read, ends on the high byte.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in || !upd) begin
      p_lock_reg <= 1'b0;
      p_held_reg <= 24'h00_0000;
    end else if (rd_p_hi) begin
      p_lock_reg <= 1'b0;
    end else if (rd_ok && !p_lock_reg
                 && (ptr_reg == sosr_pkg::ADDR_PRESS_LOW || ptr_reg == sosr_pkg::ADDR_PRESS_MID)) begin
      p_lock_reg <= 1'b1;
      p_held_reg <= p_latest_reg;
    end
  end

  // Temperature locks on its own, independent of pressure.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in || !upd) begin
      t_lock_reg <= 1'b0;
      t_held_reg <= 16'h0000;
    end else if (rd_t_hi) begin
      t_lock_reg <= 1'b0;
    end else if (rd_ok && !t_lock_reg && ptr_reg == sosr_pkg::ADDR_TEMP_LOW) begin
      t_lock_reg <= 1'b1;
      t_held_reg <= t_latest_reg;
    end
  end

  // Reading the first queue byte freezes the second until it is read.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in || !upd || srst_done) begin
      q_lock_reg <= 1'b0;
      q_second_held_reg <= 8'h00;
    end else if (rd_ok && ptr_reg == sosr_pkg::ADDR_QUEUE_FIRST) begin
      q_lock_reg <= 1'b1;
      q_second_held_reg <= queue_state_in.second;
    end else if (rd_ok && ptr_reg == sosr_pkg::ADDR_QUEUE_SECOND) begin
      q_lock_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Read data is registered; unmapped addresses read zero.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      reg_rvalid_out <= 1'b0;
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rvalid_out <= rd_ok;
      if (rd_ok) begin
        case (ptr_reg)
          sosr_pkg::ADDR_RATE_SELECT: reg_rdata_out <= rate_reg;
          sosr_pkg::ADDR_UPDATE_RELOAD: reg_rdata_out <= ctrl_reg;
          sosr_pkg::ADDR_IRQ_ROUTING: reg_rdata_out <= route_reg;
          sosr_pkg::ADDR_TRIM_LOW: reg_rdata_out <= trim_low_reg;
          sosr_pkg::ADDR_TRIM_HIGH: reg_rdata_out <= trim_high_reg;
          sosr_pkg::ADDR_EVENT_SOURCE: reg_rdata_out <= 8'h00;
          sosr_pkg::ADDR_QUEUE_FIRST: reg_rdata_out <= queue_state_in.first;
          sosr_pkg::ADDR_QUEUE_SECOND:
            reg_rdata_out <= q_lock_reg ? q_second_held_reg : queue_state_in.second;
          sosr_pkg::ADDR_SAMPLE_FLAGS: begin
            reg_rdata_out <= 8'h00;
            reg_rdata_out[sosr_pkg::P_AV_BIT] <= p_av_reg;
            reg_rdata_out[sosr_pkg::T_AV_BIT] <= t_av_reg;
            reg_rdata_out[sosr_pkg::P_OR_BIT] <= p_or_reg;
            reg_rdata_out[sosr_pkg::T_OR_BIT] <= t_or_reg;
          end
          sosr_pkg::ADDR_PRESS_LOW: reg_rdata_out <= p_view[7:0];
          sosr_pkg::ADDR_PRESS_MID: reg_rdata_out <= p_view[15:8];
          sosr_pkg::ADDR_PRESS_HIGH: reg_rdata_out <= p_view[23:16];
          sosr_pkg::ADDR_TEMP_LOW: reg_rdata_out <= t_view[7:0];
          sosr_pkg::ADDR_TEMP_HIGH: reg_rdata_out <= t_view[15:8];
          default: begin
            if (slot != 4'h8) begin
              reg_rdata_out <= gen_reg[slot[2:0]];
            end else begin
              reg_rdata_out <= 8'h00;
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The interrupt pin ORs routed data-ready with routed queue events.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      interrupt_output_pin <= 1'b0;
    end else begin
      interrupt_output_pin <= (route_reg[sosr_pkg::RDY_ROUTE_BIT] && p_av_reg)
        || |(queue_irq_in & route_reg[2:0] & sosr_pkg::QUEUE_ROUTE_MASK);
    end
  end

  // Control fields decoded for the conversion engine.
  assign output_rate_select_out = rate_reg[sosr_pkg::RATE_MSB:sosr_pkg::RATE_LSB];
  assign averaging_select_out = rate_reg[2:0];
  assign zero_reference_mode_out = gen_reg[0][sosr_pkg::ZERO_REF_BIT];
  assign trim_load_out = (state_reg == sosr_pkg::SOSR_BOOT);

endmodule : sosr_bank

`default_nettype wire

/* File: tb/sosr_bank_monitor.sv */
/* Checker of the register bank's port timing.
   Assumes it is bound to sosr_bank and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module sosr_bank_monitor (
  input wire logic core_clk_in, // Core clock.
  input wire logic rst_b_in, // Reset, active low.
  input wire logic reg_rd_in, // Read strobe.
  input wire logic reg_wr_in, // Write strobe.
  input wire logic reg_ready_out, // Accesses serviced.
  input wire logic reg_rvalid_out, // Read data valid.
  input wire logic [7:0] reg_rdata_out, // Read data.
  input wire logic [3:0] output_rate_select_out, // Rate field.
  input wire logic one_shot_req_out, // One-shot pulse.
  input wire logic trim_load_out // Trim load running.
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  // A read strobe that the bank accepts.
  sequence s_taken;
    reg_rd_in && reg_ready_out;
  endsequence
  a_read_answer: assert property (s_taken |=> reg_rvalid_out)
    else $error("Accepted read got no answer.");
  a_boot_refuse: assert property (reg_rd_in && !reg_ready_out |=> !reg_rvalid_out)
    else $error("Read answered during boot.");
  a_boot_length: assert property ($rose(rst_b_in) |-> !reg_ready_out [*8])
    else $error("Boot ended too early.");
  a_boot_trim: assert property ($fell(reg_ready_out) |-> trim_load_out [*8])
    else $error("Trim load low while boot runs.");
  a_boot_exit_off: assert property ($rose(reg_ready_out) |-> output_rate_select_out == 4'h0)
    else $error("Rate not power-down after boot.");
  a_reload_cause: assert property ($fell(reg_ready_out) |-> $past(reg_wr_in))
    else $error("Boot entered without a write.");
  a_shot_pulse: assert property (one_shot_req_out |=> !one_shot_req_out)
    else $error("One-shot request longer than a cycle.");
  a_rdata_hold: assert property (!reg_rvalid_out |-> $stable(reg_rdata_out))
    else $error("Read data moved without a read.");
endmodule : sosr_bank_monitor
bind sosr_bank sosr_bank_monitor sosr_bank_monitor_i (.core_clk_in, .rst_b_in, .reg_rd_in,
  .reg_wr_in, .reg_ready_out, .reg_rvalid_out, .reg_rdata_out, .output_rate_select_out,
  .one_shot_req_out, .trim_load_out);
`default_nettype wire

/* File: tb/sosr_host.sv */
/* Host model on the byte register port.
   Assumes the bench waits for ready before it calls these tasks, save the boot refusal read. */
`timescale 1ns/1ps
`default_nettype none
module sosr_host (
  input wire logic clk_in, // Core clock.
  input wire logic rvalid_in, // Read data valid.
  input wire logic [7:0] rdata_in, // Read data.
  output logic start_out, // Load pointer.
  output logic [7:0] addr_out, // Start address.
  output logic rd_out, // Read strobe.
  output logic wr_out, // Write strobe.
  output logic [7:0] wdata_out // Write data.
);
  logic [7:0] q [8];
  logic vld;
  // Idle port.
  initial begin
    start_out = 1'h0;
    addr_out = 8'h00;
    rd_out = 1'h0;
    wr_out = 1'h0;
    wdata_out = 8'h00;
  end
  // Loads the pointer, then inverts the stale address.
  task automatic point(input logic [7:0] a);
    @(posedge clk_in) #1 start_out = 1'h1;
    addr_out = a;
    @(posedge clk_in) #1 start_out = 1'h0;
    addr_out = ~a;
  endtask : point
  // Burst read; a caller may stop on any byte, not only a high one.
  task automatic rd(input logic [7:0] a, input int n);
    point(a);
    rd_out = 1'h1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in) #1 q[i] = rdata_in;
      vld = rvalid_in;
      if (i == n - 1) rd_out = 1'h0;
    end
  endtask : rd
  // Single write; reload and soft reset are never written together.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    point(a);
    wr_out = 1'h1;
    wdata_out = d;
    @(posedge clk_in) #1 wr_out = 1'h0;
    wdata_out = ~d;
  endtask : wr
endmodule : sosr_host
`default_nettype wire

/* File: tb/sosr_bank_bench.sv */
/* Bench of the output, status and reset register bank.
   Assumes shortened boot and soft reset counts. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module sosr_bank_bench;
  logic core_clk_in, rst_b_in, stb, rd, wr, rdy, rv, sample_valid_in, trim, shot, pin;
  logic [7:0] addr, wd, rdat;
  logic [3:0] rate;
  logic [2:0] queue_irq_in;
  sosr_pkg::sosr_sample_t sample_in;
  int err_total = 0;
  int checks_done = 0;
  sosr_bank #(.BOOT_CYCLES(20), .SOFT_RESET_CYCLES(10)) sosr_bank_i (.core_clk_in,
    .rst_b_in, .reg_start_in(stb), .reg_addr_in(addr), .reg_rd_in(rd), .reg_wr_in(wr),
    .reg_wdata_in(wd), .reg_ready_out(rdy), .reg_rvalid_out(rv), .reg_rdata_out(rdat),
    .sample_valid_in, .sample_in, .queue_state_in(16'h0000), .queue_irq_in,
    .output_rate_select_out(rate), .averaging_select_out(), .one_shot_req_out(shot),
    .zero_reference_mode_out(), .trim_load_out(trim), .interrupt_output_pin(pin));
  sosr_host sosr_host_i (.clk_in(core_clk_in), .rvalid_in(rv), .rdata_in(rdat),
    .start_out(stb), .addr_out(addr), .rd_out(rd), .wr_out(wr), .wdata_out(wd));
  initial begin
    core_clk_in = 1'h0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : cyc
  task automatic wait_ready;
    int n = 0;
    while (rdy !== 1'h1 && n < 100) begin
      cyc(1);
      n++;
    end
    if (n == 100) begin
      err_total++;
      final_report;
    end
  endtask : wait_ready
  // Reads n bytes against a table.
  task automatic rchk(input logic [7:0] a, input int n, input logic [7:0] e [6]);
    sosr_host_i.rd(a, n);
    for (int i = 0; i < n; i++) `CHK("read byte", e[i], sosr_host_i.q[i])
  endtask : rchk
  task automatic smp(input logic [23:0] p, input logic [15:0] t);
    @(posedge core_clk_in) #1 sample_valid_in = 1'h1;
    sample_in = {p, t};
    cyc(1);
    sample_valid_in = 1'h0;
    sample_in = ~sample_in;
  endtask : smp
  task automatic t_boot;
    sosr_host_i.rd(8'h24, 1);
    `CHK("boot refusal", 1'h0, sosr_host_i.vld)
    `CHK("trim load", 1'h1, trim)
    wait_ready;
    rchk(8'h24, 1, '{8'h00, 0, 0, 0, 0, 0});
    rchk(8'h12, 1, '{8'h04, 0, 0, 0, 0, 0});
    $display("boot test done");
  endtask : t_boot
  task automatic t_flags;
    smp(24'h3E841A, 16'hFE7B);
    rchk(8'h27, 1, '{8'h03, 0, 0, 0, 0, 0});
    rchk(8'h2A, 1, '{8'h3E, 0, 0, 0, 0, 0});
    rchk(8'h27, 1, '{8'h02, 0, 0, 0, 0, 0});
    rchk(8'h28, 6, '{8'h1A, 8'h84, 8'h3E, 8'h7B, 8'hFE, 8'h1A});
    rchk(8'h27, 1, '{8'h00, 0, 0, 0, 0, 0});
    smp(24'h000001, 16'h0001);
    smp(24'h000002, 16'h0002);
    rchk(8'h27, 1, '{8'h33, 0, 0, 0, 0, 0});
    sosr_host_i.rd(8'h2A, 1);
    rchk(8'h27, 1, '{8'h32, 0, 0, 0, 0, 0});
    sosr_host_i.rd(8'h2C, 1);
    rchk(8'h27, 1, '{8'h00, 0, 0, 0, 0, 0});
    $display("flag test done");
  endtask : t_flags
  task automatic t_bdu;
    sosr_host_i.wr(8'h11, 8'h08);
    smp(24'h3E841A, 16'hFE7B);
    sosr_host_i.rd(8'h28, 1);
    smp(24'h812345, 16'h0102);
    rchk(8'h29, 2, '{8'h84, 8'h3E, 0, 0, 0, 0});
    rchk(8'h28, 5, '{8'h45, 8'h23, 8'h81, 8'h02, 8'h01, 0});
    rchk(8'h27, 1, '{8'h00, 0, 0, 0, 0, 0});
    sosr_host_i.wr(8'h11, 8'h00);
    $display("block update test done");
  endtask : t_bdu
  task automatic t_irq;
    sosr_host_i.wr(8'h13, 8'h20);
    smp(24'h000003, 16'h0003);
    cyc(2);
    `CHK("ready pin", 1'h1, pin)
    sosr_host_i.rd(8'h2A, 3);
    cyc(2);
    `CHK("ready pin", 1'h0, pin)
    sosr_host_i.wr(8'h13, 8'h01);
    queue_irq_in = 3'h1;
    cyc(3);
    `CHK("queue pin", 1'h1, pin)
    queue_irq_in = 3'h6;
    cyc(3);
    `CHK("queue pin", 1'h0, pin)
    $display("interrupt test done");
  endtask : t_irq
  task automatic t_reset;
    sosr_host_i.wr(8'h1A, 8'h55);
    sosr_host_i.wr(8'h10, 8'h27);
    sosr_host_i.wr(8'h11, 8'h80);
    `CHK("reload busy", 1'h0, rdy)
    wait_ready;
    `CHK("rate", 4'h0, rate)
    rchk(8'h1A, 2, '{8'h00, 8'h00, 0, 0, 0, 0});
    rchk(8'h11, 1, '{8'h00, 0, 0, 0, 0, 0});
    sosr_host_i.wr(8'h11, 8'h01);
    `CHK("shot", 1'h1, shot)
    rchk(8'h11, 1, '{8'h01, 0, 0, 0, 0, 0});
    smp(24'h000004, 16'h0004);
    rchk(8'h11, 1, '{8'h00, 0, 0, 0, 0, 0});
    sosr_host_i.wr(8'h11, 8'h04);
    rchk(8'h11, 1, '{8'h04, 0, 0, 0, 0, 0});
    cyc(12);
    rchk(8'h11, 1, '{8'h00, 0, 0, 0, 0, 0});
    rchk(8'h13, 1, '{8'h00, 0, 0, 0, 0, 0});
    rchk(8'h27, 1, '{8'h00, 0, 0, 0, 0, 0});
    $display("reset test done");
  endtask : t_reset
  initial begin
    rst_b_in = 1'h0;
    sample_valid_in = 1'h0;
    sample_in = '0;
    queue_irq_in = 3'h0;
    cyc(20);
    rst_b_in = 1'h1;
    t_boot;
    t_flags;
    t_bdu;
    t_irq;
    t_reset;
    final_report;
  end
endmodule : sosr_bank_bench
`default_nettype wire
